// ===== rtl/clock_gen_params.svh
`ifndef CLOCK_GEN_PARAMS_SVH
`define CLOCK_GEN_PARAMS_SVH

// register indexes; byte address is four times the index
`define MCC_INDEX        18'h0_008F
`define CCD_INDEX        18'h0_FFA1
`define IRQG_INDEX       18'h0_FF94
`define MISC0_INDEX      18'h0_FFF1
`define ADDR_W           18

// master clock control fields and reset
`define MCC_RESET        8'h0A
`define MCC_FAST_OSC     7
`define MCC_KEYPAD       6
`define MCC_CARD         5
`define MCC_USB          4
`define MCC_SLOW_OSC     3
`define MCC_MULT_HI      2
`define MCC_MULT_LO      0

// core clock divider field and reset
`define CCD_RESET        6'h0C
`define CCD_FIELD_HI     5

// power-down request and wake-route bit positions
`define MISC0_PD_BIT     7
`define IRQG_ROUTE_BIT   7

// timing
`define CLK_HZ           100000000
`define SLOW_HZ          32768
`define SLOW_HALF_CYC    (`CLK_HZ / (2 * `SLOW_HZ))
`define PD_DELAY_TICKS   32
`define WAKE_DELAY_TICKS 512

`endif

// ===== rtl/clock_gen_pkg.sv
`default_nettype none
package clock_gen_pkg;
    typedef enum logic [1:0] {
        PD_RUN,
        PD_DELAY,
        PD_DOWN,
        PD_WAKE
    } pd_state_t;
endpackage
`default_nettype wire

// ===== rtl/clock_gen_power_down_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "clock_gen_params.svh"

module clock_gen_power_down_ctrl (
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    input  wire logic [19:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [19:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        slow_osc_in,
    input  wire logic [7:0]  wake_usr_in,
    input  wire logic        wake_card_in,
    input  wire logic        wake_usb_in,
    input  wire logic        wake_rtc_in,
    input  wire logic        wake_keypad_in,
    output logic             fast_osc_en_out,
    output logic             pll_en_out,
    output logic             analog_bias_en_out,
    output logic             slow_osc_en_out,
    output logic             slow_clk_out,
    output logic [2:0]       vco_multiplier_out,
    output logic             keypad_clk_en_out,
    output logic             card_clk_en_out,
    output logic             usb_clk_en_out,
    output logic             core_clk_en_out,
    output logic             core_clock_pin_out,
    output logic             wake_irq_line_out
);
    localparam int SLOW_W = 16;
    localparam logic [SLOW_W-1:0] SLOW_HALF = SLOW_W'(`SLOW_HALF_CYC);
    localparam logic [9:0] PD_TICKS   = 10'(`PD_DELAY_TICKS);
    localparam logic [9:0] WAKE_TICKS = 10'(`WAKE_DELAY_TICKS);

    typedef struct packed {
        logic [7:0]              mcc;
        logic [5:0]              div;
        logic                    pd_req;
        logic                    route;
        clock_gen_pkg::pd_state_t st;
        logic [9:0]              cnt;
        logic                    irq;
        logic [SLOW_W-1:0]       slow_cnt;
        logic                    slow_div;
        logic                    slow_clk;
        logic                    aw_h;
        logic [17:0]             aw_idx;
        logic                    w_h;
        logic [31:0]             wdata;
        logic                    wstrb0;
        logic                    bvalid;
        logic                    rvalid;
        logic [31:0]             rdata;
        logic [1:0]              rresp;
        logic [1:0]              bresp;
        logic                    fast_en;
        logic                    bias_en;
        logic                    kp_en;
        logic                    card_en;
        logic                    usb_en;
        logic                    core_en;
        logic                    aw_rdy;
        logic                    w_rdy;
        logic                    ar_rdy;
        logic                    slow_en;
    } top_state_t;

    top_state_t s_q;
    top_state_t s_d;
    logic       core_clk;
    logic       core_tick;
    logic       core_run;
    logic       wake_any;

    function automatic logic mapped(input logic [17:0] idx);
        mapped = (idx == `MCC_INDEX) || (idx == `CCD_INDEX) ||
                 (idx == `IRQG_INDEX) || (idx == `MISC0_INDEX);
    endfunction

    // core clock runs unless the analog section is shut down or the MCC fast oscillator bit is set
    assign core_run = (s_q.st != clock_gen_pkg::PD_DOWN) && !s_q.mcc[`MCC_FAST_OSC];

    core_clock_div u_div (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .run_in    (core_run),
        .div_in    (s_q.div),
        .clk_out   (core_clk),
        .tick_out  (core_tick)
    );

    assign wake_any = (|wake_usr_in) | wake_card_in | wake_usb_in |
                      wake_rtc_in | wake_keypad_in;

    always_comb begin
        logic aw_now;
        logic w_now;
        logic do_write;
        logic [17:0] ridx;
        logic pd_active;
        aw_now    = 1'b0;
        w_now     = 1'b0;
        do_write  = 1'b0;
        ridx      = s_axi_araddr[19:2];
        pd_active = 1'b0;
        s_d       = s_q;

        // write address and data may arrive in either order
        if (s_axi_awvalid && !s_q.aw_h && !s_q.bvalid) begin
            aw_now     = 1'b1;
            s_d.aw_h   = 1'b1;
            s_d.aw_idx = s_axi_awaddr[19:2];
        end
        if (s_axi_wvalid && !s_q.w_h && !s_q.bvalid) begin
            w_now      = 1'b1;
            s_d.w_h    = 1'b1;
            s_d.wdata  = s_axi_wdata;
            s_d.wstrb0 = s_axi_wstrb[0];
        end
        if (s_q.aw_h && s_q.w_h) begin
            do_write   = 1'b1;
            s_d.aw_h   = 1'b0;
            s_d.w_h    = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp  = mapped(s_q.aw_idx) ? 2'b00 : 2'b10;
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end

        if (do_write && s_q.wstrb0) begin
            if (s_q.aw_idx == `MCC_INDEX) begin
                s_d.mcc = s_q.wdata[7:0];
            end else if (s_q.aw_idx == `CCD_INDEX) begin
                s_d.div = s_q.wdata[`CCD_FIELD_HI:0];
            end else if (s_q.aw_idx == `IRQG_INDEX) begin
                s_d.route = s_q.wdata[`IRQG_ROUTE_BIT];
            end else if (s_q.aw_idx == `MISC0_INDEX) begin
                s_d.pd_req = s_q.wdata[`MISC0_PD_BIT];
            end
        end

        // read channel
        if (s_axi_arvalid && !s_q.rvalid) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = mapped(ridx) ? 2'b00 : 2'b10;
            s_d.rdata  = 32'h0000_0000;
            if (ridx == `MCC_INDEX) begin
                s_d.rdata[7:0] = s_q.mcc;
            end else if (ridx == `CCD_INDEX) begin
                s_d.rdata[`CCD_FIELD_HI:0] = s_q.div;
            end else if (ridx == `IRQG_INDEX) begin
                s_d.rdata[`IRQG_ROUTE_BIT] = s_q.route;
                s_d.route = 1'b0;
                s_d.irq   = 1'b0;
            end else if (ridx == `MISC0_INDEX) begin
                s_d.rdata[`MISC0_PD_BIT] = s_q.pd_req;
            end
        end
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end

        // power-down sequencer
        case (s_q.st)
            clock_gen_pkg::PD_RUN: begin
                s_d.cnt = 10'h000;
                if (s_q.pd_req) begin
                    s_d.st = clock_gen_pkg::PD_DELAY;
                end
            end
            clock_gen_pkg::PD_DELAY: begin
                if (core_tick) begin
                    s_d.cnt = s_q.cnt + 10'h001;
                end
                if (core_tick && (s_q.cnt == PD_TICKS - 10'h001)) begin
                    s_d.st  = clock_gen_pkg::PD_DOWN;
                    s_d.cnt = 10'h000;
                end else if (!s_q.pd_req) begin
                    s_d.st = clock_gen_pkg::PD_RUN;
                end
            end
            clock_gen_pkg::PD_DOWN: begin
                if (wake_any && s_q.route) begin
                    s_d.st     = clock_gen_pkg::PD_WAKE;
                    s_d.cnt    = 10'h000;
                    s_d.pd_req = 1'b0;
                end
            end
            clock_gen_pkg::PD_WAKE: begin
                if (core_tick) begin
                    s_d.cnt = s_q.cnt + 10'h001;
                end
                if (core_tick && (s_q.cnt == WAKE_TICKS - 10'h001)) begin
                    s_d.st  = clock_gen_pkg::PD_RUN;
                    s_d.irq = 1'b1;
                end
            end
            default: begin
                s_d.st = clock_gen_pkg::PD_RUN;
            end
        endcase

        pd_active = s_q.pd_req || (s_q.st == clock_gen_pkg::PD_DOWN);

        // slow clock follows the crystal when the oscillator is on, else derived from the main clock and held low while shut down
        if (s_q.slow_cnt >= SLOW_HALF - SLOW_W'(1)) begin
            s_d.slow_cnt = '0;
            s_d.slow_div = ~s_q.slow_div;
        end else begin
            s_d.slow_cnt = s_q.slow_cnt + SLOW_W'(1);
        end
        if (!s_q.mcc[`MCC_SLOW_OSC]) begin
            s_d.slow_clk = slow_osc_in;
        end else if (s_q.st != clock_gen_pkg::PD_DOWN) begin
            s_d.slow_clk = s_q.slow_div;
        end else begin
            s_d.slow_clk = 1'b0;
        end

        s_d.fast_en = !s_q.mcc[`MCC_FAST_OSC] && (s_d.st != clock_gen_pkg::PD_DOWN);
        s_d.bias_en = (s_d.st != clock_gen_pkg::PD_DOWN);
        s_d.kp_en   = !s_q.mcc[`MCC_KEYPAD] && !pd_active;
        s_d.card_en = !s_q.mcc[`MCC_CARD] && !pd_active;
        s_d.usb_en  = !s_q.mcc[`MCC_USB] && !pd_active;
        // follows the next state so it drops and rises with the oscillator enable
        s_d.core_en = !s_q.mcc[`MCC_FAST_OSC] && (s_d.st != clock_gen_pkg::PD_DOWN);
        s_d.aw_rdy  = !s_d.aw_h && !s_d.bvalid;
        s_d.w_rdy   = !s_d.w_h && !s_d.bvalid;
        s_d.ar_rdy  = !s_d.rvalid;
        s_d.slow_en = !s_d.mcc[`MCC_SLOW_OSC];
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s_q         <= '0;
            s_q.mcc     <= `MCC_RESET;
            s_q.div     <= `CCD_RESET;
            s_q.st      <= clock_gen_pkg::PD_RUN;
            s_q.fast_en <= 1'b1;
            s_q.bias_en <= 1'b1;
            s_q.kp_en   <= 1'b1;
            s_q.card_en <= 1'b1;
            s_q.usb_en  <= 1'b1;
            s_q.core_en <= 1'b1;
            s_q.aw_rdy  <= 1'b1;
            s_q.w_rdy   <= 1'b1;
            s_q.ar_rdy  <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign s_axi_awready      = s_q.aw_rdy;
    assign s_axi_wready       = s_q.w_rdy;
    assign s_axi_bvalid       = s_q.bvalid;
    assign s_axi_bresp        = s_q.bresp;
    assign s_axi_arready      = s_q.ar_rdy;
    assign s_axi_rvalid       = s_q.rvalid;
    assign s_axi_rdata        = s_q.rdata;
    assign s_axi_rresp        = s_q.rresp;
    assign fast_osc_en_out    = s_q.fast_en;
    assign pll_en_out         = s_q.fast_en;
    assign analog_bias_en_out = s_q.bias_en;
    assign slow_osc_en_out    = s_q.slow_en;
    assign slow_clk_out       = s_q.slow_clk;
    assign vco_multiplier_out = s_q.mcc[`MCC_MULT_HI:`MCC_MULT_LO];
    assign keypad_clk_en_out  = s_q.kp_en;
    assign card_clk_en_out    = s_q.card_en;
    assign usb_clk_en_out     = s_q.usb_en;
    assign core_clk_en_out    = s_q.core_en;
    assign core_clock_pin_out = core_clk;
    assign wake_irq_line_out  = s_q.irq;
endmodule
`default_nettype wire

// ===== rtl/core_clock_div.sv
`timescale 1ns/1ns
`default_nettype none
module core_clock_div (
    input  wire logic       clk_in,
    input  wire logic       resetn_in,
    input  wire logic       run_in,
    input  wire logic [5:0] div_in,
    output logic            clk_out,
    output logic            tick_out
);
    typedef struct packed {
        logic [5:0] cnt;
        logic       clk;
        logic       tick;
    } div_state_t;

    div_state_t s_q;
    div_state_t s_d;

    // half period of div_in+1 input cycles gives a period of 2*(div+1)
    always_comb begin
        s_d      = s_q;
        s_d.tick = 1'b0;
        if (!run_in) begin
            s_d.cnt = 6'h00;
            s_d.clk = 1'b0;
        end else if (s_q.cnt >= div_in) begin
            s_d.cnt  = 6'h00;
            s_d.clk  = ~s_q.clk;
            s_d.tick = ~s_q.clk;
        end else begin
            s_d.cnt = s_q.cnt + 6'h01;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign clk_out  = s_q.clk;
    assign tick_out = s_q.tick;
endmodule
`default_nettype wire

// ===== tb/clock_gen_far_end.sv
`timescale 1ns/1ns
`default_nettype none
module clock_gen_far_end #(parameter int HALF = 7) (
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    input  wire logic [11:0] wake_sel_in,
    output logic             slow_osc_out,
    output logic [11:0]      wake_out
);
    int cnt;
    // crystal runs free, sped up; wake lines follow the bench's command
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt <= 0;
            slow_osc_out <= 1'b0;
            wake_out <= 12'h000;
        end else begin
            cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
            slow_osc_out <= slow_osc_out ^ (cnt == HALF - 1);
            wake_out <= wake_sel_in;
        end
    end
endmodule
`default_nettype wire

// ===== tb/clock_gen_power_down_ctrl_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module clock_gen_checker (
    input wire logic       clk_in,
    input wire logic       resetn_in,
    input wire logic       slow_osc_in,
    input wire logic       fast_osc_en_out,
    input wire logic       pll_en_out,
    input wire logic       analog_bias_en_out,
    input wire logic       slow_osc_en_out,
    input wire logic       slow_clk_out,
    input wire logic [2:0] vco_multiplier_out,
    input wire logic       keypad_clk_en_out,
    input wire logic       card_clk_en_out,
    input wire logic       usb_clk_en_out,
    input wire logic       core_clk_en_out,
    input wire logic       core_clock_pin_out,
    input wire logic       wake_irq_line_out
);
    logic        pin_q;
    logic [15:0] pd_q;
    logic [15:0] wk_q;
    logic        tick;
    logic        per_off;
    assign tick = core_clock_pin_out && !pin_q;
    assign per_off = !keypad_clk_en_out && !card_clk_en_out && !usb_clk_en_out;
    // core ticks since the peripherals dropped, and since the restart
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pin_q <= 1'b0;
            pd_q <= 16'h0000;
            wk_q <= 16'h0000;
        end else begin
            pin_q <= core_clock_pin_out;
            pd_q <= (per_off && analog_bias_en_out) ? pd_q + 16'(tick) : 16'h0000;
            wk_q <= analog_bias_en_out ? wk_q + 16'(tick) : 16'h0000;
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    sequence restart_s;
        $rose(analog_bias_en_out);
    endsequence
    fast_pll_a: assert property (fast_osc_en_out == pll_en_out)
        else $error("pll and oscillator differ");
    core_stop_a: assert property (!fast_osc_en_out |-> !core_clk_en_out)
        else $error("core clock runs without oscillator");
    down_off_a: assert property (!analog_bias_en_out |-> per_off && !core_clk_en_out)
        else $error("clock running in shutdown");
    pd_delay_a: assert property ($fell(analog_bias_en_out) |-> pd_q inside {[31:33]})
        else $error("shutdown delay wrong");
    restart_a: assert property (restart_s |-> fast_osc_en_out && core_clk_en_out)
        else $error("clocks not restarted");
    wake_delay_a: assert property ($rose(wake_irq_line_out) |-> wk_q inside {[511:513]})
        else $error("wake delay wrong");
    reset_val_a: assert property ($rose(resetn_in) |-> vco_multiplier_out == 3'h2
        && !slow_osc_en_out && !per_off && fast_osc_en_out) else $error("bad reset state");
    slow_src_a: assert property (slow_osc_en_out && $past(slow_osc_en_out)
        |-> slow_clk_out == $past(slow_osc_in)) else $error("slow clock not from crystal");
endmodule
bind clock_gen_power_down_ctrl clock_gen_checker chk (
    .clk_in, .resetn_in, .slow_osc_in, .fast_osc_en_out, .pll_en_out, .analog_bias_en_out,
    .slow_osc_en_out, .slow_clk_out, .vco_multiplier_out, .keypad_clk_en_out,
    .card_clk_en_out, .usb_clk_en_out, .core_clk_en_out, .core_clock_pin_out,
    .wake_irq_line_out
);
`default_nettype wire

// ===== tb/clock_gen_power_down_ctrl_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "clock_gen_params.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module clock_gen_power_down_ctrl_bench;
    logic        clk_in = 1'b0, resetn_in = 1'b0;
    logic [19:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd_v;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [1:0]  b_v, rr_v;
    logic        slow_osc_in, wake_card_in, wake_usb_in, wake_rtc_in, wake_keypad_in;
    logic [7:0]  wake_usr_in;
    logic        fast_osc_en_out, pll_en_out, analog_bias_en_out, slow_osc_en_out;
    logic        slow_clk_out, keypad_clk_en_out, card_clk_en_out, usb_clk_en_out;
    logic        core_clk_en_out, core_clock_pin_out, wake_irq_line_out;
    logic [2:0]  vco_multiplier_out;
    logic [11:0] wake_sel = '0;
    int          n_fail = 0, comparisons = 0, cyc = 0, n;

    clock_gen_power_down_ctrl uut (
        .clk_in, .resetn_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .slow_osc_in, .wake_usr_in, .wake_card_in, .wake_usb_in,
        .wake_rtc_in, .wake_keypad_in, .fast_osc_en_out, .pll_en_out, .analog_bias_en_out,
        .slow_osc_en_out, .slow_clk_out, .vco_multiplier_out, .keypad_clk_en_out,
        .card_clk_en_out, .usb_clk_en_out, .core_clk_en_out, .core_clock_pin_out,
        .wake_irq_line_out
    );
    clock_gen_far_end far (
        .clk_in, .resetn_in, .wake_sel_in(wake_sel), .slow_osc_out(slow_osc_in),
        .wake_out({wake_keypad_in, wake_rtc_in, wake_usb_in, wake_card_in, wake_usr_in})
    );

    initial begin
        forever #5 clk_in = ~clk_in;
    end

    task automatic results;
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 90000) begin
            n_fail++;
            results();
        end
    end

    // write lets the outputs settle before returning
    task automatic wr(input logic [17:0] idx, input logic [7:0] d);
        @(posedge clk_in);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_in);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        b_v = s_axi_bresp;
        s_axi_bready <= 1'b0;
        repeat (2) @(posedge clk_in);
    endtask

    task automatic rd(input logic [17:0] idx);
        @(posedge clk_in);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_in);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd_v = s_axi_rdata;
        rr_v = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic period(input logic slow, output int p);
        time t0;
        @(posedge (slow ? slow_clk_out : core_clock_pin_out));
        t0 = $time;
        @(posedge (slow ? slow_clk_out : core_clock_pin_out));
        p = int'(($time - t0) / 10);
    endtask

    initial begin
        repeat (6) @(posedge clk_in);
        resetn_in <= 1'b1;
        rd(`MCC_INDEX);
        `CHK(rd_v, 32'h0000_000a)
        rd(`CCD_INDEX);
        `CHK(rd_v, 32'h0000_000c)
        rd(18'h0_0010);
        `CHK({rr_v, rd_v}, 34'h2_0000_0000)
        wr(18'h0_0010, 8'h55);
        `CHK(b_v, 2'b10)
        period(1'b1, n);
        `CHK(n, 2 * `SLOW_HALF_CYC)
        period(1'b0, n);
        `CHK(n, 26)
        for (int i = 0; i < 8; i++) begin
            wr(`MCC_INDEX, {1'b0, 3'(i), 1'b0, 3'(7 - i)});
            `CHK(vco_multiplier_out, 3'(7 - i))
            `CHK({keypad_clk_en_out, card_clk_en_out, usb_clk_en_out}, ~3'(i))
            `CHK(slow_osc_en_out, 1'b1)
        end
        wr(`MCC_INDEX, 8'h8a);
        `CHK({fast_osc_en_out, pll_en_out}, 2'b00)
        wr(`MCC_INDEX, 8'h0a);
        // a write without the low byte strobe is answered but changes nothing
        s_axi_wstrb <= 4'h0;
        wr(`MCC_INDEX, 8'hff);
        s_axi_wstrb <= 4'hf;
        `CHK(b_v, 2'b00)
        rd(`MCC_INDEX);
        `CHK(rd_v, 32'h0000_000a)
        wr(`CCD_INDEX, 8'h02);
        period(1'b0, n);
        period(1'b0, n);
        `CHK(n, 6)
        for (int s = 0; s < 12; s++) begin
            wr(`IRQG_INDEX, 8'h80);
            wr(`MISC0_INDEX, 8'h80);
            while (analog_bias_en_out) @(posedge clk_in);
            `CHK({fast_osc_en_out, keypad_clk_en_out, core_clk_en_out}, 3'b000)
            wake_sel <= 12'h001 << s;
            while (!wake_irq_line_out) @(posedge clk_in);
            wake_sel <= 12'h000;
            `CHK({fast_osc_en_out, analog_bias_en_out}, 2'b11)
            rd(`MISC0_INDEX);
            `CHK(rd_v, 32'h0000_0000)
            rd(`IRQG_INDEX);
            `CHK(rd_v, 32'h0000_0080)
            rd(`IRQG_INDEX);
            `CHK({rd_v, wake_irq_line_out}, 33'h0_0000_0000)
        end
        results();
    end
endmodule
`default_nettype wire
